// >>> rtl/talrt_alert_therm.sv
// Purpose: comparator-mode alert, critical output, averaging and conversion pacing
// Assumes: results arrive from the converter on mclk, one channel per strobe
// Notes: interrupt-mode alert behaviour lives outside; here the pin then stays released
`default_nettype none
//
// Contract
// - comparator alert when temperature reaches high limit
// - low limit and diode fault never alert
// - alert holds until all below high minus hysteresis
// - high queue counter gates each channel's alert
// - alert sets summary and per-channel high status
// - status read cannot clear while alert asserted
// - status clears when alert deasserts
// - global mask ignored in comparator mode
// - channel mask blocks alert, status still set
// - critical output independent and never masked
// - critical asserts after queued linked over-limit readings
// - critical holds until all below limit minus hysteresis
// - averaging selected per channel
// - averaged value is mean of last four
// - averaging off after reset, enabled per channel
// - four conversions per second after reset
// - dynamic averaging stretches time, keeps rate
// - scale 4x, 2x, 1x, half by rate
// - dynamic averaging default on; off gives 1x, except continuous stays at half
// - alert pin open drain active low, mode bit
// - saturated high counter holds until release margin
// - one hysteresis for critical and comparator release
module talrt_alert_therm #(
    parameter int unsigned CONV_1PS_CYC =
        talrt_pkg::T_1PS_MS * (talrt_pkg::NS_PER_MS / talrt_pkg::CLK_NS),
    parameter int unsigned CONV_2PS_CYC =
        talrt_pkg::T_2PS_MS * (talrt_pkg::NS_PER_MS / talrt_pkg::CLK_NS),
    parameter int unsigned CONV_4PS_CYC =
        talrt_pkg::T_4PS_MS * (talrt_pkg::NS_PER_MS / talrt_pkg::CLK_NS),
    parameter int unsigned CONV_CONT_CYC =
        talrt_pkg::T_CONT_MS * (talrt_pkg::NS_PER_MS / talrt_pkg::CLK_NS)
) (
    input wire logic mclk,
    input wire logic resetn,
    // converter results
    input wire logic resValid,
    input wire logic [talrt_pkg::CHW-1:0] resChan,
    input wire logic [talrt_pkg::TW-1:0] resTemp,
    // configuration
    input wire logic compMode,
    input wire logic maskAll,
    input wire logic dynAvgOff,
    input wire logic [talrt_pkg::RW-1:0] convRate,
    input wire logic [talrt_pkg::NCH*talrt_pkg::TW-1:0] highLimit,
    input wire logic [talrt_pkg::NCH*talrt_pkg::TW-1:0] critLimit,
    input wire logic [talrt_pkg::TW-1:0] critHyst,
    input wire logic [talrt_pkg::NCH-1:0] chanMask,
    input wire logic [talrt_pkg::NCH-1:0] critLink,
    input wire logic [talrt_pkg::NCH-1:0] filterEn,
    input wire logic [talrt_pkg::QW-1:0] highQueue,
    input wire logic [talrt_pkg::QW-1:0] critQueue,
    input wire logic statusRead,
    // outputs
    output logic alertOut,
    output logic alertOe,
    output logic thermOut,
    output logic thermOe,
    output logic statusHigh,
    output logic [talrt_pkg::NCH-1:0] highStatus,
    output logic [talrt_pkg::NCH-1:0] critStatus,
    output logic repValid,
    output logic [talrt_pkg::CHW-1:0] repChan,
    output logic [talrt_pkg::TW-1:0] repTemp,
    output logic convStart,
    output logic [talrt_pkg::SW-1:0] integScale
);
    localparam int NCH = talrt_pkg::NCH;
    localparam int TW = talrt_pkg::TW;
    localparam int QW = talrt_pkg::QW;
    localparam int CW = talrt_pkg::CW;

    // per-channel views of the packed configuration
    logic [TW-1:0] highLim [NCH];
    logic [TW-1:0] critLim [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_split
            assign highLim[g] = highLimit[g*TW +: TW];
            assign critLim[g] = critLimit[g*TW +: TW];
        end
    endgenerate

    // ---------------- averaging ----------------
    // each channel keeps four raw
    // samples, newest in slot 0
    // the history always shifts,
    // even with averaging off, so
    // turning the filter on later
    // needs no warm-up of its own
    // until three prior samples
    // exist the raw value is used
    // sum is two bits wider than
    // a sample so it cannot wrap
    // the mean is a plain shift;
    // fractions are dropped
    logic [TW-1:0] hist [NCH][talrt_pkg::HIST];   // last samples per channel
    logic [TW-1:0] next_hist [NCH][talrt_pkg::HIST];
    logic [talrt_pkg::HIW:0] fill [NCH];          // samples seen, saturates at depth
    logic [talrt_pkg::HIW:0] next_fill [NCH];
    logic [TW-1:0] curTemp;                       // value used for limits and reporting
    logic [TW+1:0] avgSum;

    // history shift and the reported value for the strobed channel
    always_comb begin
        next_hist = hist;
        next_fill = fill;
        avgSum = {2'b00, resTemp} + {2'b00, hist[resChan][0]}
               + {2'b00, hist[resChan][1]} + {2'b00, hist[resChan][2]};
        curTemp = resTemp;
        // internal channel never averages; warm-up uses raw values
        if (filterEn[resChan] && resChan != CHW_INT()
            && fill[resChan] >= 3'(talrt_pkg::HIST - 1)) begin
            curTemp = avgSum[TW+1:2];             // mean of last four
        end
        if (resValid) begin
            next_hist[resChan][0] = resTemp;
            for (int k = 1; k < talrt_pkg::HIST; k++) begin
                next_hist[resChan][k] = hist[resChan][k-1];
            end
            if (fill[resChan] != 3'(talrt_pkg::HIST)) begin
                next_fill[resChan] = fill[resChan] + 3'h1;
            end
        end
    end

    function automatic logic [talrt_pkg::CHW-1:0] CHW_INT();
        return talrt_pkg::CHW'(talrt_pkg::INT_CH);
    endfunction

    // ---------------- limit queues ----------------
    // one counter per channel for
    // the high limit and one for
    // the critical limit
    // a counter that meets its
    // setting sets the held bit
    // and then stops counting
    // a held channel only lets go
    // below limit minus margin
    // the margin add is nine bits
    // wide so a large hysteresis
    // cannot underflow the limit
    // only the strobed channel moves
    logic [QW-1:0] highCnt [NCH];                 // consecutive high readings
    logic [QW-1:0] next_highCnt [NCH];
    logic [NCH-1:0] highHeld, next_highHeld;      // queue satisfied, holding
    logic [QW-1:0] critCnt [NCH];
    logic [QW-1:0] next_critCnt [NCH];
    logic [NCH-1:0] critHeld, next_critHeld;
    logic [TW:0] relHigh, relCrit;                // temperature plus release margin

    // once-per-result evaluation of the strobed channel only
    always_comb begin
        next_highCnt = highCnt;
        next_highHeld = highHeld;
        next_critCnt = critCnt;
        next_critHeld = critHeld;
        relHigh = {1'b0, curTemp} + {1'b0, critHyst}; // shared margin
        relCrit = {1'b0, curTemp} + {1'b0, critHyst};
        if (resValid) begin
            // high queue: only the high limit counts, low and faults ignored
            if (curTemp >= highLim[resChan]) begin
                if (!highHeld[resChan]) begin
                    if (highCnt[resChan] >= highQueue) begin
                        next_highHeld[resChan] = 1'b1;
                    end else begin
                        next_highCnt[resChan] = highCnt[resChan] + 3'h1;
                    end
                end
            end else if (highHeld[resChan]) begin
                // saturated counter waits for the release margin
                if (relHigh < {1'b0, highLim[resChan]}) begin
                    next_highHeld[resChan] = 1'b0;
                    next_highCnt[resChan] = talrt_pkg::QCNT_RST;
                end
            end else begin
                next_highCnt[resChan] = talrt_pkg::QCNT_RST;
            end
            // critical queue with hysteresis release
            if (curTemp >= critLim[resChan]) begin
                if (!critHeld[resChan]) begin
                    if (critCnt[resChan] >= critQueue) begin
                        next_critHeld[resChan] = 1'b1;
                    end else begin
                        next_critCnt[resChan] = critCnt[resChan] + 3'h1;
                    end
                end
            end else if (relCrit < {1'b0, critLim[resChan]}) begin
                next_critHeld[resChan] = 1'b0;
                next_critCnt[resChan] = talrt_pkg::QCNT_RST;
            end
        end
    end

    // ---------------- outputs and status ----------------
    // pin state is worked out from
    // the next held bits so pins
    // follow the result by one
    // cycle, not two
    // status sets are applied last
    // so a set beats a read clear
    // or a release clear in the
    // same cycle
    // a masked channel still sets
    // its status but never the pin
    // with the pin released, a read
    // clears masked leftovers
    logic alertAct, next_alertAct;                // pin pulled low
    logic thermAct, next_thermAct;
    logic [NCH-1:0] next_highStatus;
    logic next_statusHigh;

    // pin state and sticky high status
    always_comb begin
        // maskAll deliberately unused here: comparator mode ignores it
        // per-channel mask only gates the pin
        next_alertAct = compMode && |(next_highHeld & ~chanMask);
        // critical pin ignores every mask
        next_thermAct = |(next_critHeld & critLink);
        next_highStatus = highStatus;
        if (statusRead && !alertAct) begin
            next_highStatus = '0;                     // no clear while pin asserted
        end
        if (alertAct && !next_alertAct) begin
            next_highStatus = '0;                     // automatic clear
        end
        if (compMode) begin
            // newly held channels set status even when masked; set beats clear
            next_highStatus = next_highStatus | (next_highHeld & ~highHeld);
            if (next_alertAct) begin
                next_highStatus = next_highStatus | next_highHeld;
            end
        end
        next_statusHigh = |next_highStatus;
    end

    // ---------------- conversion pacing ----------------
    // the counter loads the period
    // minus one at each start and
    // counts down to zero
    // zero after reset gives a
    // start on the first edge
    // a rate change to a shorter
    // period cuts the wait short
    // rather than finishing the
    // old one
    // scale and start leave on the
    // same edge as registers
    // limitation: 32-bit counter
    // covers the slowest rate
    logic [CW-1:0] periodCnt, next_periodCnt;     // cycles left in this conversion
    logic [CW-1:0] periodLen;
    logic next_convStart;
    logic [talrt_pkg::SW-1:0] next_integScale;

    // rate decode, integration scale and start strobe
    always_comb begin
        if (convRate >= talrt_pkg::RATE_CONT) begin
            periodLen = CW'(CONV_CONT_CYC);
            next_integScale = talrt_pkg::SCALE_HALF; // half either way
        end else if (convRate == talrt_pkg::RATE_4PS) begin
            periodLen = CW'(CONV_4PS_CYC);
            next_integScale = talrt_pkg::SCALE_1X;
        end else if (convRate == talrt_pkg::RATE_2PS) begin
            periodLen = CW'(CONV_2PS_CYC);
            next_integScale = dynAvgOff ? talrt_pkg::SCALE_1X : talrt_pkg::SCALE_2X;
        end else begin
            // slower codes run at one per second
            periodLen = CW'(CONV_1PS_CYC);
            next_integScale = dynAvgOff ? talrt_pkg::SCALE_1X : talrt_pkg::SCALE_4X;
        end
        // longer integration never moves the start spacing
        next_convStart = 1'b0;
        next_periodCnt = periodCnt - CW'(1);
        if (periodCnt == talrt_pkg::CNT_RST || periodCnt > periodLen) begin
            // a rate change shortens a running wait at once
            next_convStart = 1'b1;
            next_periodCnt = periodLen - CW'(1);
        end
    end

    // all state registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < NCH; c++) begin
                for (int k = 0; k < talrt_pkg::HIST; k++) begin
                    hist[c][k] <= talrt_pkg::TEMP_RST;
                end
                fill[c] <= '0;
                highCnt[c] <= talrt_pkg::QCNT_RST;
                critCnt[c] <= talrt_pkg::QCNT_RST;
            end
            highHeld <= '0;
            critHeld <= '0;
            alertAct <= 1'b0;
            thermAct <= 1'b0;
            alertOut <= 1'b0;
            alertOe <= 1'b0;
            thermOut <= 1'b0;
            thermOe <= 1'b0;
            highStatus <= '0;
            statusHigh <= 1'b0;
            critStatus <= '0;
            repValid <= 1'b0;
            repChan <= '0;
            repTemp <= talrt_pkg::TEMP_RST;
            periodCnt <= talrt_pkg::CNT_RST;       // first start right after reset
            convStart <= 1'b0;
            integScale <= talrt_pkg::SCALE_1X;     // matches the 4/s reset rate
        end else begin
            hist <= next_hist;
            fill <= next_fill;
            highCnt <= next_highCnt;
            critCnt <= next_critCnt;
            highHeld <= next_highHeld;
            critHeld <= next_critHeld;
            alertAct <= next_alertAct;
            thermAct <= next_thermAct;
            // open drain: output level stays low, enable pulls the pin
            alertOut <= 1'b0;
            alertOe <= next_alertAct;
            thermOut <= 1'b0;
            thermOe <= next_thermAct;
            highStatus <= next_highStatus;
            statusHigh <= next_statusHigh;
            critStatus <= next_critHeld;
            repValid <= resValid;
            repChan <= resChan;
            repTemp <= curTemp;
            periodCnt <= next_periodCnt;
            convStart <= next_convStart;
            integScale <= next_integScale;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/talrt_pkg.sv
// Purpose: shared constants for the alert / critical output block
// Assumes: one result per channel arrives as a one-cycle strobe
// Notes: rate codes above the documented default are this block's own encoding
`default_nettype none
package talrt_pkg;
    localparam int NCH = 8;                  // internal plus seven remote channels
    localparam int CHW = 3;                  // channel index width
    localparam int TW = 8;                   // integer temperature width
    localparam int QW = 3;                   // queue setting width, count = setting + 1
    localparam int HIST = 4;                 // running average depth
    localparam int HIW = 2;                  // history index width
    localparam int RW = 4;                   // conversion rate code width
    localparam int SW = 4;                   // integration scale width, in half units
    localparam int INT_CH = 0;               // internal channel is never averaged
    // conversion rate codes
    localparam logic [RW-1:0] RATE_1PS = 4'h4;
    localparam logic [RW-1:0] RATE_2PS = 4'h5;
    localparam logic [RW-1:0] RATE_4PS = 4'h6; // reset rate
    localparam logic [RW-1:0] RATE_CONT = 4'h7; // this code and above run continuous
    // integration scale against normal 11-bit time, counted in halves
    localparam logic [SW-1:0] SCALE_4X = 4'h8;
    localparam logic [SW-1:0] SCALE_2X = 4'h4;
    localparam logic [SW-1:0] SCALE_1X = 4'h2;
    localparam logic [SW-1:0] SCALE_HALF = 4'h1;
    // timing
    localparam int CLK_NS = 10;              // mclk period
    localparam int NS_PER_MS = 1000000;
    localparam int T_1PS_MS = 1000;          // period at one conversion per second
    localparam int T_2PS_MS = 500;
    localparam int T_4PS_MS = 250;
    localparam int T_CONT_MS = 84;           // back-to-back cycle of all channels
    localparam int CW = 32;                  // period counter width
    // reset values of the block's own state
    localparam logic [QW-1:0] QCNT_RST = 3'h0;
    localparam logic [TW-1:0] TEMP_RST = 8'h00;
    localparam logic [CW-1:0] CNT_RST = 32'h00000000;
endpackage
`default_nettype wire

// >>> tb/talrt_alert_therm_chk.sv
// Purpose: port-level checks on the alert / critical output block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into every instance of the block by the bind below
`default_nettype none
module talrt_alert_therm_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic resValid,
    input wire logic [talrt_pkg::CHW-1:0] resChan,
    input wire logic [talrt_pkg::TW-1:0] resTemp,
    input wire logic compMode,
    input wire logic dynAvgOff,
    input wire logic [talrt_pkg::RW-1:0] convRate,
    input wire logic [talrt_pkg::NCH-1:0] filterEn,
    input wire logic statusRead,
    input wire logic alertOut,
    input wire logic alertOe,
    input wire logic thermOut,
    input wire logic thermOe,
    input wire logic statusHigh,
    input wire logic [talrt_pkg::NCH-1:0] highStatus,
    input wire logic repValid,
    input wire logic [talrt_pkg::CHW-1:0] repChan,
    input wire logic [talrt_pkg::TW-1:0] repTemp,
    input wire logic convStart,
    input wire logic [talrt_pkg::SW-1:0] integScale
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic [talrt_pkg::SW-1:0] expScale; // scale the rate setting asks for
    // reference scale table; codes below one per second run as one per second
    always_comb begin
        if (convRate >= talrt_pkg::RATE_CONT) begin
            expScale = talrt_pkg::SCALE_HALF; // continuous is half even with averaging off
        end else if (dynAvgOff || convRate == talrt_pkg::RATE_4PS) begin
            expScale = talrt_pkg::SCALE_1X;
        end else if (convRate == talrt_pkg::RATE_2PS) begin
            expScale = talrt_pkg::SCALE_2X;
        end else begin
            expScale = talrt_pkg::SCALE_4X;
        end
    end
    property p_rep_pulse; resValid |=> repValid && repChan == $past(resChan); endproperty
    a_rep_pulse: assert property (p_rep_pulse) else $error("report missing after result");
    property p_rep_quiet; !resValid |=> !repValid; endproperty
    a_rep_quiet: assert property (p_rep_quiet) else $error("report without result");
    property p_raw_temp; resValid && !filterEn[resChan] |=> repTemp == $past(resTemp); endproperty
    a_raw_temp: assert property (p_raw_temp) else $error("unfiltered value altered");
    property p_alert_hold; !resValid && compMode && $past(compMode) |=> $stable(alertOe);
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert moved without result");
    property p_sum; statusHigh == (|highStatus); endproperty
    a_sum: assert property (p_sum) else $error("summary flag disagrees");
    property p_alert_stat; alertOe |-> statusHigh; endproperty
    a_alert_stat: assert property (p_alert_stat) else $error("alert without status");
    property p_read_keep; statusRead && alertOe && !resValid |=> highStatus == $past(highStatus);
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("read cleared live status");
    property p_fall_clr; $fell(alertOe) |-> highStatus == '0; endproperty
    a_fall_clr: assert property (p_fall_clr) else $error("status kept after release");
    property p_pins; !alertOut && !thermOut; endproperty
    a_pins: assert property (p_pins) else $error("open-drain pin driven high");
    property p_therm_hold; !resValid |=> $stable(thermOe); endproperty
    a_therm_hold: assert property (p_therm_hold) else $error("critical moved without result");
    property p_scale; 1'b1 |=> integScale == $past(expScale); endproperty
    a_scale: assert property (p_scale) else $error("integration scale wrong");
    property p_conv; convStart |=> !convStart; endproperty
    a_conv: assert property (p_conv) else $error("conversion strobe too long");
endmodule
bind talrt_alert_therm talrt_alert_therm_chk chk_u (.mclk(mclk), .resetn(resetn),
    .resValid(resValid), .resChan(resChan), .resTemp(resTemp), .compMode(compMode),
    .dynAvgOff(dynAvgOff), .convRate(convRate), .filterEn(filterEn), .statusRead(statusRead),
    .alertOut(alertOut), .alertOe(alertOe), .thermOut(thermOut), .thermOe(thermOe),
    .statusHigh(statusHigh), .highStatus(highStatus), .repValid(repValid), .repChan(repChan),
    .repTemp(repTemp), .convStart(convStart), .integScale(integScale));
`default_nettype wire

// >>> tb/talrt_host_model.sv
// Purpose: host side of the alert and critical lines
// Assumes: both lines carry pull-ups on the board
// Notes: a released line reads high, never the last driven level
`default_nettype none
module talrt_host_model (
    input wire logic alertOut,
    input wire logic alertOe,
    input wire logic thermOut,
    input wire logic thermOe,
    output logic alertN,
    output logic thermN
);
    timeunit 1ns;
    timeprecision 100ps;
    // wired level seen by the host interrupt input
    assign alertN = alertOe ? alertOut : 1'b1;
    // wired level seen by the shutdown input
    assign thermN = thermOe ? thermOut : 1'b1;
endmodule
`default_nettype wire

// >>> tb/temp_alert_therm_output_logic_bench.sv
// Purpose: directed tests of alert, critical, averaging and pacing
// Assumes: short conversion periods set by parameter
// Notes: high limit 50h, critical 60h, hysteresis 0Ah throughout
`default_nettype none
module temp_alert_therm_output_logic_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int C1 = 40, C2 = 20, C4 = 10, CC = 5; // shortened periods keep the run brief
    localparam logic [talrt_pkg::RW-1:0] RATES [4] = '{talrt_pkg::RATE_1PS, talrt_pkg::RATE_2PS,
        talrt_pkg::RATE_4PS, talrt_pkg::RATE_CONT};
    localparam logic [talrt_pkg::SW-1:0] SC_ON [4] = '{talrt_pkg::SCALE_4X, talrt_pkg::SCALE_2X,
        talrt_pkg::SCALE_1X, talrt_pkg::SCALE_HALF};
    localparam logic [talrt_pkg::SW-1:0] SC_OFF [4] = '{talrt_pkg::SCALE_1X, talrt_pkg::SCALE_1X,
        talrt_pkg::SCALE_1X, talrt_pkg::SCALE_HALF};
    localparam int PERS [4] = '{C1, C2, C4, CC};
    logic mclk = 1'b0, resetn = 1'b0, resValid = 1'b0, statusRead = 1'b0;
    logic compMode = 1'b1, maskAll = 1'b1, dynAvgOff = 1'b0; // global mask stays set on purpose
    logic [talrt_pkg::CHW-1:0] resChan = '0;
    logic [talrt_pkg::TW-1:0] resTemp = '0, critHyst = 8'h0A;
    logic [talrt_pkg::RW-1:0] convRate = talrt_pkg::RATE_4PS;
    logic [talrt_pkg::NCH*talrt_pkg::TW-1:0] highLimit = {8{8'h50}}, critLimit = {8{8'h60}};
    logic [talrt_pkg::NCH-1:0] chanMask = '0, critLink = 8'h30, filterEn = '0;
    logic [talrt_pkg::QW-1:0] highQueue = 3'h1, critQueue = 3'h0; // two high readings, one critical
    logic alertOut, alertOe, thermOut, thermOe, statusHigh, repValid, convStart, alertN, thermN;
    logic [talrt_pkg::NCH-1:0] highStatus, critStatus;
    logic [talrt_pkg::CHW-1:0] repChan;
    logic [talrt_pkg::TW-1:0] repTemp;
    logic [talrt_pkg::SW-1:0] integScale;
    int failures = 0, checks = 0, n;
    talrt_alert_therm #(.CONV_1PS_CYC(C1), .CONV_2PS_CYC(C2), .CONV_4PS_CYC(C4),
        .CONV_CONT_CYC(CC)) dut_u (.mclk(mclk), .resetn(resetn), .resValid(resValid),
        .resChan(resChan), .resTemp(resTemp), .compMode(compMode), .maskAll(maskAll),
        .dynAvgOff(dynAvgOff), .convRate(convRate), .highLimit(highLimit), .critLimit(critLimit),
        .critHyst(critHyst), .chanMask(chanMask), .critLink(critLink), .filterEn(filterEn),
        .highQueue(highQueue), .critQueue(critQueue), .statusRead(statusRead),
        .alertOut(alertOut), .alertOe(alertOe), .thermOut(thermOut), .thermOe(thermOe),
        .statusHigh(statusHigh), .highStatus(highStatus), .critStatus(critStatus),
        .repValid(repValid), .repChan(repChan), .repTemp(repTemp), .convStart(convStart),
        .integScale(integScale));
    talrt_host_model host_u (.alertOut(alertOut), .alertOe(alertOe), .thermOut(thermOut),
        .thermOe(thermOe), .alertN(alertN), .thermN(thermN));
    // free-running 100 MHz clock
    initial forever #5 mclk = ~mclk;
    // one result strobe; outputs are read just after the edge that takes it
    task automatic send(input logic [talrt_pkg::CHW-1:0] ch, input logic [talrt_pkg::TW-1:0] t);
        @(posedge mclk);
        resValid <= 1'b1;
        resChan <= ch;
        resTemp <= t;
        @(posedge mclk);
        resValid <= 1'b0;
        #1;
    endtask
    // one software read of the high status
    task automatic rd();
        @(posedge mclk);
        statusRead <= 1'b1;
        @(posedge mclk);
        statusRead <= 1'b0;
        #1;
    endtask
    // cycles from one conversion strobe to the next, bounded
    task automatic per(output int cnt);
        cnt = 0;
        while (convStart !== 1'b1 && cnt < 100) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (convStart !== 1'b1 && cnt < 100);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog: the tests need well under 2000 cycles
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        #1;
        chk(8'(convStart), 8'h01);
        chk(8'(integScale), 8'(talrt_pkg::SCALE_1X));
        $display("test reset done");
        // the four named rate codes, averaging on then off, with its period
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            convRate <= RATES[i];
            dynAvgOff <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            chk(8'(integScale), 8'(SC_ON[i]));
            per(n);
            per(n);
            chk(8'(n), 8'(PERS[i]));
            @(posedge mclk);
            dynAvgOff <= 1'b1;
            repeat (2) @(posedge mclk);
            #1;
            chk(8'(integScale), 8'(SC_OFF[i]));
        end
        @(posedge mclk);
        convRate <= talrt_pkg::RATE_4PS;
        dynAvgOff <= 1'b0;
        compMode <= 1'b0;
        send(3'h1, 8'h50);
        send(3'h1, 8'h50);
        chk(8'(alertOe), 8'h00);
        send(3'h1, 8'h40);
        rd();
        compMode <= 1'b1;
        $display("test rates and mode done");
        send(3'h1, 8'h50);
        chk(8'(alertOe), 8'h00);
        send(3'h1, 8'h50);
        chk(8'(alertN), 8'h00);
        chk(highStatus, 8'h02);
        rd();
        chk(highStatus, 8'h02);
        send(3'h1, 8'h48);
        send(3'h1, 8'h50);
        chk(8'(alertOe), 8'h01);
        send(3'h2, 8'h51);
        send(3'h2, 8'h51);
        send(3'h1, 8'h45);
        chk(8'(alertOe), 8'h01);
        chk(highStatus, 8'h06);
        send(3'h2, 8'h40);
        chk(8'(alertN), 8'h01);
        chk(highStatus, 8'h00);
        send(3'h3, 8'h50);
        send(3'h3, 8'h4F);
        send(3'h3, 8'h50);
        chk(8'(alertOe), 8'h00);
        send(3'h3, 8'h40);
        chanMask <= 8'h08;
        send(3'h3, 8'h50);
        send(3'h3, 8'h50);
        chk(8'(alertOe), 8'h00);
        chk(highStatus, 8'h08);
        send(3'h3, 8'h40);
        rd();
        chk(highStatus, 8'h00);
        $display("test alert done");
        chanMask <= 8'hFF;
        send(3'h4, 8'h60);
        chk(8'(thermN), 8'h00);
        chk(critStatus, 8'h10);
        send(3'h4, 8'h57);
        chk(8'(thermOe), 8'h01);
        send(3'h4, 8'h55);
        chk(8'(thermOe), 8'h00);
        send(3'h6, 8'h70);
        chk(8'(thermOe), 8'h00);
        chk(critStatus, 8'h40);
        send(3'h6, 8'h40);
        send(3'h4, 8'h40);
        rd();
        chanMask <= 8'h00;
        $display("test critical done");
        send(3'h5, 8'h20);
        chk(repTemp, 8'h20);
        filterEn <= 8'h20;
        send(3'h5, 8'h10);
        send(3'h5, 8'h20);
        send(3'h5, 8'h30);
        send(3'h5, 8'h40);
        chk(repTemp, 8'h28);
        send(3'h6, 8'h33);
        chk(repTemp, 8'h33);
        send(3'h5, 8'h4C);
        chk(repTemp, 8'h37);
        $display("test averaging done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
